// file: shared/fgt_defs.vh
// Constants for the fine gain trim and FIR configuration register slice
`ifndef FGT_DEFS_VH
`define FGT_DEFS_VH

// ****************************************
// Register indices as printed; byte address = index * 4
// ****************************************
`define FGT_IDX_GAIN_B0_DUAL 16'h0352
`define FGT_IDX_GAIN_B1_DUAL 16'h0353
`define FGT_IDX_GAIN_A0_SINGLE 16'h0354
`define FGT_IDX_GAIN_A1_SINGLE 16'h0355
`define FGT_IDX_GAIN_B0_SINGLE 16'h0356
`define FGT_IDX_GAIN_B1_SINGLE 16'h0357
`define FGT_IDX_FIR_CONFIG 16'h0400
`define FGT_IDX_FIR_TAP0 16'h0418
`define FGT_IDX_STATUS 16'h0440

// ****************************************
// Field positions
// ****************************************
`define FGT_GAIN_MSB 4
`define FGT_GAIN_W 5
`define FGT_GAIN_CNT 6
`define FGT_CFG_SHARE 6
`define FGT_CFG_MERGE 5
`define FGT_CFG_SCW_MSB 4
`define FGT_CFG_SCW_LSB 2
`define FGT_CFG_MODE_MSB 1
`define FGT_CFG_MODE_LSB 0
`define FGT_TAP_MSB 11
`define FGT_ST_FUSE_DONE 0
`define FGT_ST_FIR_ON 1
`define FGT_ST_LATE_WR 2
`define FGT_ST_MODE_RSV 3
`define FGT_ST_SER_EN 4

// ****************************************
// Reset values and encodings
// ****************************************
`define FGT_RST_GAIN 5'h00
`define FGT_RST_CFG 7'h00
`define FGT_RST_TAP 12'h000
`define FGT_MODE_OFF 2'h0
`define FGT_MODE_ON 2'h2
`define FGT_SCW_MAX 3'h6
`define FGT_SCW_BIAS 16
`define FGT_RESP_OKAY 2'h0
`define FGT_RESP_SLVERR 2'h2

`endif

// file: hw/fgt_axil_port.v
// AXI4-Lite slave front end issuing single-cycle register strobes
`timescale 1ns/1ps
`include "fgt_defs.vh"
module fgt_axil_port (
	input wire sys_clk,
	input wire reset_n,
	input wire [15:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [15:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire wr_allow,
	output wire wr_en,
	output wire [15:0] wr_addr,
	output wire [31:0] wr_data,
	output wire [3:0] wr_strb,
	input wire wr_hit,
	output wire [15:0] rd_addr,
	input wire [31:0] rd_data,
	input wire rd_hit
);
	reg aw_full_reg;
	reg w_full_reg;
	reg ar_full_reg;
	reg [15:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg [15:0] ar_addr_reg;

	// Write fires only once both halves are held and no answer is pending
	assign wr_en = aw_full_reg & w_full_reg & ~s_axi_bvalid & wr_allow;
	assign wr_addr = aw_addr_reg;
	assign wr_data = w_data_reg;
	assign wr_strb = w_strb_reg;
	assign rd_addr = ar_addr_reg;

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			ar_full_reg <= 1'b0;
			aw_addr_reg <= 16'h0000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			ar_addr_reg <= 16'h0000;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FGT_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `FGT_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			s_axi_awready <= ~aw_full_reg & ~s_axi_awready;
			s_axi_wready <= ~w_full_reg & ~s_axi_wready;
			s_axi_arready <= ~ar_full_reg & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_en) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `FGT_RESP_OKAY : `FGT_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				ar_full_reg <= 1'b1;
				ar_addr_reg <= s_axi_araddr;
			end
			if (ar_full_reg && !s_axi_rvalid) begin
				ar_full_reg <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_hit ? `FGT_RESP_OKAY : `FGT_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // fgt_axil_port

// file: hw/fgt_regs.v
// Fine gain trim and programmable FIR configuration register slice
//
// Functional notes
// - B dual-mode bank trims: 5 bits, upper reserved
// - Four separate single-mode trims, A and B banks
// - Trim defaults come from fuse memory after reset
// - Share bit: B filter uses A coefficients
// - Merge bit: one filter, one interleaved stream
// - Side weight scales non-center taps, 2^(w-16)
// - Mode 0 off, 2 on, 1 and 3 reserved
// - Tap 0: 12-bit signed, first filter tap
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fgt_defs.vh"
module fgt_regs (
	input wire sys_clk,
	input wire reset_n,
	input wire [15:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [15:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output reg [2:0] fuse_addr,
	input wire [4:0] fuse_data,
	input wire serial_out_enable,
	output wire [4:0] fine_gain_b_bank0_dual,
	output wire [4:0] fine_gain_b_bank1_dual,
	output wire [4:0] fine_gain_a_bank0_single,
	output wire [4:0] fine_gain_a_bank1_single,
	output wire [4:0] fine_gain_b_bank0_single,
	output wire [4:0] fine_gain_b_bank1_single,
	output reg fir_active,
	output reg coef_share,
	output reg filter_merge,
	output reg [2:0] side_coef_weight,
	output reg [4:0] side_lsb_neg_exp,
	output reg [11:0] fir_coef_tap0,
	output reg fuse_load_done
);
	// ****************************************
	// Local state codes
	// ****************************************
	localparam ST_FUSE_ADDR = 2'd0;
	localparam ST_FUSE_DATA = 2'd1;
	localparam ST_RUN = 2'd2;

	localparam SEL_NONE = 3'd0;
	localparam SEL_GAIN = 3'd1;
	localparam SEL_CFG = 3'd2;
	localparam SEL_TAP = 3'd3;
	localparam SEL_STAT = 3'd4;

	// ****************************************
	// Address decode helpers
	// ****************************************
	// Word index of a byte address; low bits must be zero
	function [15:0] word_idx;
		input [15:0] addr;
		begin
			word_idx = {2'b00, addr[15:2]};
		end
	endfunction

	function [2:0] reg_sel;
		input [15:0] addr;
		reg [15:0] idx;
		begin
			idx = word_idx(addr);
			reg_sel = SEL_NONE;
			if (addr[1:0] != 2'b00)
				reg_sel = SEL_NONE;
			else if (idx >= `FGT_IDX_GAIN_B0_DUAL && idx <= `FGT_IDX_GAIN_B1_SINGLE)
				reg_sel = SEL_GAIN;
			else if (idx == `FGT_IDX_FIR_CONFIG)
				reg_sel = SEL_CFG;
			else if (idx == `FGT_IDX_FIR_TAP0)
				reg_sel = SEL_TAP;
			else if (idx == `FGT_IDX_STATUS)
				reg_sel = SEL_STAT;
		end
	endfunction

	// Slot 0..5 of the trim array, in printed order
	function [2:0] gain_slot;
		input [15:0] addr;
		reg [15:0] diff;
		begin
			diff = word_idx(addr) - `FGT_IDX_GAIN_B0_DUAL;
			gain_slot = diff[2:0];
		end
	endfunction

	// ****************************************
	// Storage
	// ****************************************
	reg [4:0] gain_reg [0:5];
	reg [6:0] cfg_reg;
	reg [11:0] tap0_reg;
	reg [1:0] state_reg;
	reg [2:0] fuse_cnt_reg;
	reg late_wr_reg;
	reg ser_meta_reg;
	reg ser_sync_reg;

	wire wr_en;
	wire [15:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [15:0] rd_addr;
	reg [31:0] rd_data;
	reg rd_hit;
	wire [2:0] wr_sel;
	wire [2:0] rd_sel;
	wire wr_hit;
	wire fir_write;

	assign wr_sel = reg_sel(wr_addr);
	assign rd_sel = reg_sel(rd_addr);
	assign wr_hit = (wr_sel != SEL_NONE);
	assign fir_write = wr_en && (wr_sel == SEL_CFG || wr_sel == SEL_TAP);

	assign fine_gain_b_bank0_dual = gain_reg[0];
	assign fine_gain_b_bank1_dual = gain_reg[1];
	assign fine_gain_a_bank0_single = gain_reg[2];
	assign fine_gain_a_bank1_single = gain_reg[3];
	assign fine_gain_b_bank0_single = gain_reg[4];
	assign fine_gain_b_bank1_single = gain_reg[5];

	// ****************************************
	// Bus front end
	// ****************************************
	// Protection bits carry no meaning here
	fgt_axil_port fgt_axil_port_inst (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_allow(state_reg == ST_RUN),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_hit(wr_hit),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// ****************************************
	// Serial output enable synchroniser
	// ****************************************
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			ser_meta_reg <= 1'b0;
			ser_sync_reg <= 1'b0;
		end else begin
			ser_meta_reg <= serial_out_enable;
			ser_sync_reg <= ser_meta_reg;
		end
	end

	// ****************************************
	// Fuse load sequencer and register writes
	// ****************************************
	// Fuse read has one cycle of latency; bus writes wait until done
	integer i;
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			state_reg <= ST_FUSE_ADDR;
			fuse_cnt_reg <= 3'd0;
			fuse_addr <= 3'd0;
			fuse_load_done <= 1'b0;
			for (i = 0; i < `FGT_GAIN_CNT; i = i + 1)
				gain_reg[i] <= `FGT_RST_GAIN;
			cfg_reg <= `FGT_RST_CFG;
			tap0_reg <= `FGT_RST_TAP;
			late_wr_reg <= 1'b0;
		end else begin
			case (state_reg)
			ST_FUSE_ADDR: begin
				fuse_addr <= fuse_cnt_reg;
				state_reg <= ST_FUSE_DATA;
			end
			ST_FUSE_DATA: begin
				gain_reg[fuse_cnt_reg] <= fuse_data;
				if (fuse_cnt_reg == 3'd5) begin
					state_reg <= ST_RUN;
					fuse_load_done <= 1'b1;
				end else begin
					fuse_cnt_reg <= fuse_cnt_reg + 3'd1;
					state_reg <= ST_FUSE_ADDR;
				end
			end
			ST_RUN: begin
				if (wr_en && wr_strb[0]) begin
					case (wr_sel)
					SEL_GAIN: begin
						gain_reg[gain_slot(wr_addr)] <= wr_data[4:0];
					end
					SEL_CFG: begin
						cfg_reg <= wr_data[6:0];
					end
					SEL_TAP: begin
						tap0_reg[7:0] <= wr_data[7:0];
					end
					default: begin
					end
					endcase
				end
				if (wr_en && wr_strb[1] && wr_sel == SEL_TAP)
					tap0_reg[11:8] <= wr_data[11:8];
				// Sticky flag: new event wins over a write-one clear
				if (fir_write && ser_sync_reg)
					late_wr_reg <= 1'b1;
				else if (wr_en && wr_strb[0] && wr_sel == SEL_STAT &&
					wr_data[`FGT_ST_LATE_WR])
					late_wr_reg <= 1'b0;
			end
			default: begin
				state_reg <= ST_FUSE_ADDR;
			end
			endcase
		end
	end

	// ****************************************
	// Filter control outputs
	// ****************************************
	// Reserved modes keep the filter off, so only code 2 runs it
	wire mode_on;
	wire [2:0] scw;
	assign mode_on = (cfg_reg[`FGT_CFG_MODE_MSB:`FGT_CFG_MODE_LSB] == `FGT_MODE_ON);
	assign scw = cfg_reg[`FGT_CFG_SCW_MSB:`FGT_CFG_SCW_LSB];

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			fir_active <= 1'b0;
			coef_share <= 1'b0;
			filter_merge <= 1'b0;
			side_coef_weight <= 3'd0;
			side_lsb_neg_exp <= 5'd16;
			fir_coef_tap0 <= `FGT_RST_TAP;
		end else begin
			fir_active <= mode_on;
			if (mode_on) begin
				coef_share <= cfg_reg[`FGT_CFG_SHARE];
				filter_merge <= cfg_reg[`FGT_CFG_MERGE];
				side_coef_weight <= scw;
				side_lsb_neg_exp <= 5'd16 - {2'b00, scw};
				fir_coef_tap0 <= tap0_reg;
			end else begin
				// Bypass: settings are held off the datapath
				coef_share <= 1'b0;
				filter_merge <= 1'b0;
				side_coef_weight <= 3'd0;
				side_lsb_neg_exp <= 5'd16;
				fir_coef_tap0 <= `FGT_RST_TAP;
			end
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	// Reserved bits are not stored and read as zero
	always @* begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		case (rd_sel)
		SEL_GAIN: begin
			rd_data[4:0] = gain_reg[gain_slot(rd_addr)];
		end
		SEL_CFG: begin
			rd_data[6:0] = cfg_reg;
		end
		SEL_TAP: begin
			rd_data[11:0] = tap0_reg;
		end
		SEL_STAT: begin
			rd_data[`FGT_ST_FUSE_DONE] = fuse_load_done;
			rd_data[`FGT_ST_FIR_ON] = fir_active;
			rd_data[`FGT_ST_LATE_WR] = late_wr_reg;
			rd_data[`FGT_ST_MODE_RSV] = cfg_reg[0];
			rd_data[`FGT_ST_SER_EN] = ser_sync_reg;
		end
		default: begin
			rd_hit = 1'b0;
		end
		endcase
	end
endmodule // fgt_regs

// file: verification/fgt_regs_asserts.sv
// Port checker for the fine gain trim and FIR configuration slice
`timescale 1ns/1ps
module fgt_regs_asserts (
	input wire sys_clk,
	input wire reset_n,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [4:0] fine_gain_b_bank0_dual,
	input wire [4:0] fine_gain_a_bank0_single,
	input wire fir_active,
	input wire coef_share,
	input wire filter_merge,
	input wire [2:0] side_coef_weight,
	input wire [4:0] side_lsb_neg_exp,
	input wire [11:0] fir_coef_tap0,
	input wire fuse_load_done
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_bwait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence s_settled;
		fuse_load_done && $past(fuse_load_done) && !$rose(s_axi_bvalid);
	endsequence
	property p_bhold;
		s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_off;
		!fir_active |-> fir_coef_tap0 == 12'h000 && !coef_share && !filter_merge
			&& side_coef_weight == 3'h0;
	endproperty
	property p_exp;
		side_lsb_neg_exp == 5'h10 - {2'b00, side_coef_weight};
	endproperty
	property p_done;
		fuse_load_done |=> fuse_load_done;
	endproperty
	property p_wr_hold;
		!fuse_load_done |-> !s_axi_bvalid;
	endproperty
	property p_gain;
		s_settled |-> $stable({fine_gain_b_bank0_dual, fine_gain_a_bank0_single});
	endproperty
	property p_fir;
		$changed(fir_active) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	a_off: assert property (p_off) else $error("filter settings leak while off");
	a_exp: assert property (p_exp) else $error("side weight exponent wrong");
	a_done: assert property (p_done) else $error("load done fell");
	a_wr_hold: assert property (p_wr_hold) else $error("write before load");
	a_gain: assert property (p_gain) else $error("trim moved without write");
	a_fir: assert property (p_fir) else $error("filter state moved alone");
endmodule // fgt_regs_asserts

// file: verification/fgt_regs_tb.sv
// Self-checking bench for the fine gain trim and FIR configuration slice
`timescale 1ns/1ps
module fgt_regs_tb;
	typedef struct packed {
		logic [15:0] a;
		logic [31:0] d;
		logic [31:0] r;
		logic [1:0] s;
		logic [17:0] o;
	} fgt_row_t;
	logic sys_clk = 0, reset_n = 0, serial_out_enable = 0;
	logic [15:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [2:0] fuse_addr;
	logic fir_active, coef_share, filter_merge, fuse_load_done;
	logic [2:0] side_coef_weight;
	logic [4:0] side_lsb_neg_exp;
	logic [11:0] fir_coef_tap0;
	wire [29:0] gains;
	int error_cnt = 0, num_checks = 0, i;
	fgt_row_t rows [13] = '{
		'{16'h0D48, 32'h0000_00FF, 32'h0000_001F, 2'h0, 18'h0_0000},
		'{16'h0D4C, 32'h0000_000A, 32'h0000_000A, 2'h0, 18'h0_0000},
		'{16'h0D50, 32'h0000_0011, 32'h0000_0011, 2'h0, 18'h0_0000},
		'{16'h0D54, 32'h0000_00E3, 32'h0000_0003, 2'h0, 18'h0_0000},
		'{16'h0D58, 32'h0000_001C, 32'h0000_001C, 2'h0, 18'h0_0000},
		'{16'h0D5C, 32'h0000_0005, 32'h0000_0005, 2'h0, 18'h0_0000},
		'{16'h1060, 32'hFFFF_F800, 32'h0000_0800, 2'h0, 18'h0_0000},
		'{16'h1000, 32'h0000_007A, 32'h0000_007A, 2'h0, 18'h3_E800},
		'{16'h1000, 32'h0000_0001, 32'h0000_0001, 2'h0, 18'h0_0000},
		'{16'h1000, 32'h0000_0083, 32'h0000_0003, 2'h0, 18'h0_0000},
		'{16'h1000, 32'h0000_0006, 32'h0000_0006, 2'h0, 18'h2_1800},
		'{16'h1004, 32'h0000_0005, 32'h0000_0000, 2'h2, 18'h2_1800},
		'{16'h1060, 32'h0000_07FF, 32'h0000_07FF, 2'h0, 18'h2_17FF}
	};
	always #10 sys_clk = ~sys_clk;
	fgt_regs fgt_regs_inst (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .fuse_addr(fuse_addr),
		// Fuse word tracks its index so each slot is recognisable
		.fuse_data(5'h10 + {2'b00, fuse_addr}), .serial_out_enable(serial_out_enable),
		.fine_gain_b_bank0_dual(gains[4:0]), .fine_gain_b_bank1_dual(gains[9:5]),
		.fine_gain_a_bank0_single(gains[14:10]), .fine_gain_a_bank1_single(gains[19:15]),
		.fine_gain_b_bank0_single(gains[24:20]), .fine_gain_b_bank1_single(gains[29:25]),
		.fir_active(fir_active), .coef_share(coef_share), .filter_merge(filter_merge),
		.side_coef_weight(side_coef_weight), .side_lsb_neg_exp(side_lsb_neg_exp),
		.fir_coef_tap0(fir_coef_tap0), .fuse_load_done(fuse_load_done)
	);
	task automatic results;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input [31:0] e, input [31:0] s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic stall;
		error_cnt++;
		results();
	endtask
	task automatic wr(input [15:0] a, input [31:0] d, input [1:0] er);
		int n;
		bit go;
		go = 1;
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		for (n = 0; n < 200 && go; n++) begin
			@(posedge sys_clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) begin
				chk("bresp", 32'(er), 32'(bresp));
				bready <= 0;
				go = 0;
			end
		end
		if (go) stall();
		@(posedge sys_clk);
	endtask
	task automatic rd(input [15:0] a, input [31:0] e, input [1:0] er);
		int n;
		bit go;
		go = 1;
		araddr <= a; arvalid <= 1; rready <= 1;
		for (n = 0; n < 200 && go; n++) begin
			@(posedge sys_clk);
			if (arready) arvalid <= 0;
			if (rvalid) begin
				chk("rdata", e, rdata);
				chk("rresp", 32'(er), 32'(rresp));
				rready <= 0;
				go = 0;
			end
		end
		if (go) stall();
		@(posedge sys_clk);
	endtask
	task automatic do_reset;
		reset_n <= 0;
		repeat (12) @(posedge sys_clk);
		reset_n <= 1;
		@(posedge sys_clk);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		do_reset();
		rd(16'h1000, 32'h0, 2'h0);
		chk("neg_exp", 32'h10, 32'(side_lsb_neg_exp));
		for (i = 0; i < 100 && fuse_load_done !== 1'b1; i++) @(posedge sys_clk);
		if (i == 100) stall();
		for (i = 0; i < 6; i++) begin
			rd(16'(16'h0D48 + 4 * i), 32'(16 + i), 2'h0);
			chk("gain_pin", 32'(16 + i), 32'(gains[5 * i +: 5]));
		end
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d, rows[k].s);
			rd(rows[k].a, rows[k].r, rows[k].s);
			if (k < 6) chk("gain_pin", rows[k].r, 32'(gains[5 * k +: 5]));
			chk("filter", 32'(rows[k].o), 32'({fir_active, coef_share, filter_merge,
				side_coef_weight, fir_coef_tap0}));
		end
		// Serial link up: trims may change, filter untouched, so no late-write flag
		serial_out_enable <= 1;
		repeat (2) @(posedge sys_clk);
		wr(16'h0D50, 32'h0000_0009, 2'h0);
		chk("gain_pin", 32'h9, 32'(gains[14:10]));
		rd(16'h1100, 32'h0000_0013, 2'h0);
		serial_out_enable <= 0;
		// Second reset: a write issued at once must wait out the fuse load
		do_reset();
		wr(16'h0D48, 32'h0000_0007, 2'h0);
		chk("load_done", 32'h1, 32'(fuse_load_done));
		rd(16'h0D48, 32'h0000_0007, 2'h0);
		rd(16'h0D4C, 32'h0000_0011, 2'h0);
		rd(16'h1060, 32'h0, 2'h0);
		results();
	end
endmodule // fgt_regs_tb
bind fgt_regs fgt_regs_asserts fgt_regs_asserts_inst (
	.sys_clk, .reset_n, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .fine_gain_b_bank0_dual, .fine_gain_a_bank0_single,
	.fir_active, .coef_share, .filter_merge, .side_coef_weight, .side_lsb_neg_exp,
	.fir_coef_tap0, .fuse_load_done
);
